// file: logic/ctm_top.sv
// compact timer: register slave, output pin logic and match flags
// What this block does
// R1 - mode 00 is compare-match output; counter clears by overflow, a match or p match
// R2 - clear-select low: p match or zero-p overflow clears; p flag raised, a flag only for a nonzero a value
// R3 - clear-select high: a match clears, only a flag raised, never p
// R4 - clear on a with zero a value: overflow at 3ff, no a flag
// R5 - compare mode: pin changes only on a match, p match leaves it alone
// R6 - a match drives pin high, low or toggles per output function; 00 nothing
// R7 - counter-on rising loads the pin with the initial level
// R8 - mode 11 counts and flags as compare mode but leaves pin undriven
// R9 - mode 10 generates pwm and ignores clear-select
// R10 - swap bit 0: p sets period, a duty; swap bit 1 reverses
// R11 - p compares top three counter bits, steps of 128, 000 means 1024
// R12 - pwm mode raises a flag on a match and p flag on p match
// R13 - duty at or above period gives full active output
// R14 - initial-level bit picks pwm polarity; output function passes pwm or forces level
// R15 - output-invert bit inverts the pin level
// R16 - pwm counting and matching continue while pin is forced
// R17 - each period clear starts a new pwm period
// R18 - no software write to counter; only counter-on rise clears it
// R19 - comparator a checks all counter bits
// R20 - counter-on rise zeroes counter; fall stops it holding its value
// R21 - pause holds counter and counting resumes from there
// R22 - software switches timer off before changing mode or output function
// R23 - compare mode output codes: 01 low, 10 high, 11 toggle
// R24 - pwm pre-polarity active below duty value, inactive until period clear
// R25 - flags set in the match cycle and stay until software clears them
`timescale 1ns/1ps
`default_nettype none
`include "ctm_defines.svh"

module ctm_top
  import ctm_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int CNT_W = `CTM_CNT_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic timer_out,
  output logic timer_out_en,
  output logic match_a_flag,
  output logic match_p_flag
);

  initial begin
    if (ADDR_W < 8) $error("ctm_top: address width below 8 bits");
    if (CNT_W != `CTM_CNT_W) $error("ctm_top: only a 10-bit counter is supported");
  end

  typedef struct packed {
    ctm_ctrl_s ctrl;
    logic on_prev;
    logic cmp_level;
    logic pin;
    logic pin_en;
    logic flag_a;
    logic flag_p;
    logic aw_got;
    logic [ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ctm_top_state_s;

  ctm_top_state_s st;
  ctm_top_state_s next_st;
  logic rise;
  logic hit_a;
  logic hit_p;
  logic period_clr;
  logic [CNT_W-1:0] count;
  logic aw_hs;
  logic w_hs;
  logic do_write;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [CNT_W:0] duty;
  logic [CNT_W:0] period;
  logic pwm_raw;
  logic act_lvl;
  logic [1:0] clr_flags;

  // on-bit edge is taken from the stored copy, so restart follows the write by one cycle
  assign rise = st.ctrl.on && !st.on_prev; // [R7] [R20]

  ctm_counter #(
    .CNT_W(CNT_W)
  ) u_counter (
    .aclk(aclk),
    .aresetn(aresetn),
    .ctrl(st.ctrl),
    .restart(rise),
    .count(count),
    .hit_a(hit_a),
    .hit_p(hit_p),
    .period_clr(period_clr)
  );

  function automatic logic [31:0] ctm_read(input ctm_top_state_s s, input logic [7:0] ofs,
                                           input logic [CNT_W-1:0] c);
    logic [31:0] v;
    v = '0;
    unique case (ofs)
      `CTM_OFS_CTRL0: begin
        v[`CTM_C0_PAUSE] = s.ctrl.pause;
        v[`CTM_C0_ON] = s.ctrl.on;
        v[`CTM_C0_RP_HI:`CTM_C0_RP_LO] = s.ctrl.compare_p_value;
      end
      `CTM_OFS_CTRL1: begin
        v[`CTM_C1_MODE_HI:`CTM_C1_MODE_LO] = s.ctrl.mode;
        v[`CTM_C1_IO_HI:`CTM_C1_IO_LO] = s.ctrl.io;
        v[`CTM_C1_OC] = s.ctrl.oc;
        v[`CTM_C1_POL] = s.ctrl.pol;
        v[`CTM_C1_DPX] = s.ctrl.dpx;
        v[`CTM_C1_CCLR] = s.ctrl.cclr;
      end
      `CTM_OFS_CMPA: v[CNT_W-1:0] = s.ctrl.compare_a_value;
      `CTM_OFS_COUNT: v[CNT_W-1:0] = c;
      `CTM_OFS_FLAGS: begin
        v[`CTM_FL_A] = s.flag_a;
        v[`CTM_FL_P] = s.flag_p;
      end
      default: v = '0;
    endcase
    ctm_read = v;
  endfunction

  function automatic logic ctm_mapped(input logic [7:0] ofs);
    ctm_mapped = (ofs == `CTM_OFS_CTRL0) || (ofs == `CTM_OFS_CTRL1) || (ofs == `CTM_OFS_CMPA) ||
                 (ofs == `CTM_OFS_COUNT) || (ofs == `CTM_OFS_FLAGS);
  endfunction

  always_comb begin
    next_st = st;
    clr_flags = 2'h0;
    aw_hs = s_axi_awvalid && s_axi_awready;
    w_hs = s_axi_wvalid && s_axi_wready;
    wr_addr = st.aw_got ? st.aw_addr : s_axi_awaddr;
    wr_data = st.w_got ? st.w_data : s_axi_wdata;
    wr_strb = st.w_got ? st.w_strb : s_axi_wstrb;
    do_write = (st.aw_got || aw_hs) && (st.w_got || w_hs);
    next_st.on_prev = st.ctrl.on;

    // write channel: address and data in either order, answer after both
    if (aw_hs) begin
      next_st.aw_got = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (w_hs) begin
      next_st.w_got = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (do_write) begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = ctm_mapped(wr_addr[7:0]) ? `CTM_RESP_OKAY : `CTM_RESP_SLVERR;
      unique case (wr_addr[7:0])
        `CTM_OFS_CTRL0: begin
          if (wr_strb[0]) begin
            next_st.ctrl.pause = wr_data[`CTM_C0_PAUSE];
            next_st.ctrl.on = wr_data[`CTM_C0_ON];
            next_st.ctrl.compare_p_value = wr_data[`CTM_C0_RP_HI:`CTM_C0_RP_LO];
          end
        end
        `CTM_OFS_CTRL1: begin
          if (wr_strb[0]) begin
            next_st.ctrl.mode = ctm_mode_e'(wr_data[`CTM_C1_MODE_HI:`CTM_C1_MODE_LO]);
            next_st.ctrl.io = wr_data[`CTM_C1_IO_HI:`CTM_C1_IO_LO];
            next_st.ctrl.oc = wr_data[`CTM_C1_OC];
            next_st.ctrl.pol = wr_data[`CTM_C1_POL];
            next_st.ctrl.dpx = wr_data[`CTM_C1_DPX];
            next_st.ctrl.cclr = wr_data[`CTM_C1_CCLR];
          end
        end
        `CTM_OFS_CMPA: begin
          if (wr_strb[0]) next_st.ctrl.compare_a_value[7:0] = wr_data[7:0];
          if (wr_strb[1]) next_st.ctrl.compare_a_value[CNT_W-1:8] = wr_data[CNT_W-1:8];
        end
        `CTM_OFS_FLAGS: begin
          if (wr_strb[0]) clr_flags = {wr_data[`CTM_FL_P], wr_data[`CTM_FL_A]};
        end
        default: begin
        end
      endcase
    end

    // read channel: one word in flight, answer the cycle after the address
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = ctm_read(st, s_axi_araddr[7:0], count);
      next_st.rresp = ctm_mapped(s_axi_araddr[7:0]) ? `CTM_RESP_OKAY : `CTM_RESP_SLVERR;
    end

    // sticky flags: a match in the clearing cycle survives the clear
    next_st.flag_a = (st.flag_a && !clr_flags[0]) || hit_a; // [R25] [R2] [R12]
    next_st.flag_p = (st.flag_p && !clr_flags[1]) || hit_p; // [R25] [R2] [R12]

    // compare-mode pin level, also tracked in timer mode but never shown there
    if (rise) begin
      next_st.cmp_level = st.ctrl.oc; // [R7]
    end else if (hit_a) begin
      unique case (st.ctrl.io)
        `CTM_IO_LOW: next_st.cmp_level = 1'b0; // [R6] [R23]
        `CTM_IO_HIGH: next_st.cmp_level = 1'b1; // [R6] [R23]
        `CTM_IO_TOGGLE: next_st.cmp_level = !st.cmp_level; // [R6] [R23]
        default: next_st.cmp_level = st.cmp_level; // [R6]
      endcase
    end

    // edge-aligned pwm; counting runs on whatever the output function is
    duty = st.ctrl.dpx ? ctm_p_point(st.ctrl.compare_p_value) : ctm_target({1'b0, st.ctrl.compare_a_value}); // [R10]
    period = st.ctrl.dpx ? ctm_target({1'b0, st.ctrl.compare_a_value}) : ctm_p_point(st.ctrl.compare_p_value); // [R10]
    pwm_raw = ({1'b0, count} < duty) || (duty >= period); // [R24] [R13] [R16]
    act_lvl = st.ctrl.oc; // [R14]
    unique case (st.ctrl.io)
      `CTM_IO_NONE: next_st.pin = !act_lvl ^ st.ctrl.pol; // [R14] [R15]
      `CTM_IO_LOW: next_st.pin = act_lvl ^ st.ctrl.pol; // [R14] [R15]
      `CTM_IO_PWM: next_st.pin = (pwm_raw ? act_lvl : !act_lvl) ^ st.ctrl.pol; // [R14] [R15]
      default: next_st.pin = !act_lvl ^ st.ctrl.pol;
    endcase

    unique case (st.ctrl.mode)
      CTM_MODE_CMP: begin
        next_st.pin = next_st.cmp_level ^ st.ctrl.pol; // [R5] [R15]
        next_st.pin_en = 1'b1;
      end
      CTM_MODE_PWM: next_st.pin_en = 1'b1; // [R9]
      default: begin
        // timer mode and the undefined code leave the pin to other functions
        next_st.pin = 1'b0; // [R8]
        next_st.pin_en = 1'b0; // [R8]
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.ctrl.compare_a_value <= `CTM_CMPA_RST;
    end else begin
      st <= next_st;
    end
  end

  assign s_axi_awready = !st.aw_got && !st.bvalid;
  assign s_axi_wready = !st.w_got && !st.bvalid;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign timer_out = st.pin;
  assign timer_out_en = st.pin_en;
  assign match_a_flag = st.flag_a;
  assign match_p_flag = st.flag_p;

  a_restart_zero: assert property (@(posedge aclk) disable iff (!aresetn) // [R20] [R18]
    rise |=> (count == '0))
    else $error("counter not zero after on-bit rise");

  a_stop_holds: assert property (@(posedge aclk) disable iff (!aresetn) // [R20]
    (!st.ctrl.on && !rise) |=> $stable(count))
    else $error("counter moved while off");

  a_pause_holds: assert property (@(posedge aclk) disable iff (!aresetn) // [R21]
    (st.ctrl.pause && !rise) |=> $stable(count))
    else $error("counter moved while paused");

  a_no_p_flag: assert property (@(posedge aclk) disable iff (!aresetn) // [R3]
    (st.ctrl.mode != CTM_MODE_PWM && st.ctrl.cclr && !st.flag_p) |=> !st.flag_p)
    else $error("p flag raised with clear on a");

  a_ovf_no_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R4]
    (st.ctrl.mode == CTM_MODE_CMP && st.ctrl.cclr && st.ctrl.compare_a_value == '0 && st.ctrl.on &&
     !st.ctrl.pause && !rise && count == `CTM_CNT_MAX) |-> !hit_a ##1 (count == '0))
    else $error("overflow with zero a value misbehaved");

  a_pin_on_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R5]
    (st.ctrl.mode == CTM_MODE_CMP && !hit_a && !rise) |=> $stable(st.cmp_level))
    else $error("compare pin changed without a match");

  a_pin_toggle: assert property (@(posedge aclk) disable iff (!aresetn) // [R6] [R23]
    (hit_a && !rise && st.ctrl.io == `CTM_IO_TOGGLE) |=> (st.cmp_level != $past(st.cmp_level)))
    else $error("toggle on a match missing");

  a_init_level: assert property (@(posedge aclk) disable iff (!aresetn) // [R7]
    (rise && st.ctrl.mode == CTM_MODE_CMP) |=> (timer_out == $past(st.ctrl.oc ^ st.ctrl.pol)))
    else $error("pin not loaded with initial level");

  a_timer_pin_off: assert property (@(posedge aclk) disable iff (!aresetn) // [R8]
    (st.ctrl.mode == CTM_MODE_TIMER) |=> !timer_out_en)
    else $error("pin driven in timer mode");

  a_full_duty: assert property (@(posedge aclk) disable iff (!aresetn) // [R13]
    (st.ctrl.mode == CTM_MODE_PWM && st.ctrl.io == `CTM_IO_PWM && duty >= period)
      |=> (timer_out == $past(act_lvl ^ st.ctrl.pol)))
    else $error("full duty not held active");

  a_period_wrap: assert property (@(posedge aclk) disable iff (!aresetn) // [R17]
    (st.ctrl.mode == CTM_MODE_PWM && period_clr && !rise) |=> (count == '0))
    else $error("pwm period clear did not restart counter");

  a_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn) // [R25]
    (hit_a) |=> st.flag_a ##1 (st.flag_a || $past(clr_flags[0])))
    else $error("a flag lost without a clear");

endmodule // ctm_top

`default_nettype wire

// file: logic/ctm_defines.svh
// constants of the compact timer: offsets, field positions, reset values, counter geometry
`ifndef CTM_DEFINES_SVH
`define CTM_DEFINES_SVH

// register byte offsets
`define CTM_OFS_CTRL0 8'h00
`define CTM_OFS_CTRL1 8'h04
`define CTM_OFS_CMPA 8'h08
`define CTM_OFS_COUNT 8'h0c
`define CTM_OFS_FLAGS 8'h10

// control word 0 fields
`define CTM_C0_PAUSE 7
`define CTM_C0_ON 3
`define CTM_C0_RP_HI 2
`define CTM_C0_RP_LO 0

// control word 1 fields
`define CTM_C1_MODE_HI 7
`define CTM_C1_MODE_LO 6
`define CTM_C1_IO_HI 5
`define CTM_C1_IO_LO 4
`define CTM_C1_OC 3
`define CTM_C1_POL 2
`define CTM_C1_DPX 1
`define CTM_C1_CCLR 0

// flag register fields
`define CTM_FL_A 0
`define CTM_FL_P 1

// counter geometry
`define CTM_CNT_W 10
`define CTM_P_W 3
`define CTM_P_SHIFT 7
`define CTM_CNT_MAX 10'h3ff
`define CTM_FULL_SPAN 11'h400

// output-function codes
`define CTM_IO_NONE 2'h0
`define CTM_IO_LOW 2'h1
`define CTM_IO_HIGH 2'h2
`define CTM_IO_TOGGLE 2'h3
`define CTM_IO_PWM 2'h2

// bus answers and reset values
`define CTM_RESP_OKAY 2'h0
`define CTM_RESP_SLVERR 2'h2
`define CTM_CTRL0_RST 8'h00
`define CTM_CTRL1_RST 8'h00
`define CTM_CMPA_RST 10'h000

`endif

// file: logic/ctm_pkg.sv
// types and shared arithmetic of the compact timer
`include "ctm_defines.svh"

package ctm_pkg;

  typedef enum logic [1:0] {
    CTM_MODE_CMP,
    CTM_MODE_UNDEF,
    CTM_MODE_PWM,
    CTM_MODE_TIMER
  } ctm_mode_e;

  typedef struct packed {
    logic pause;
    logic on;
    logic [`CTM_P_W-1:0] compare_p_value;
    ctm_mode_e mode;
    logic [1:0] io;
    logic oc;
    logic pol;
    logic dpx;
    logic cclr;
    logic [`CTM_CNT_W-1:0] compare_a_value;
  } ctm_ctrl_s;

  // comparator match point; an all-zero value stands for the full span
  function automatic logic [`CTM_CNT_W:0] ctm_target(input logic [`CTM_CNT_W:0] v);
    ctm_target = (v == '0) ? `CTM_FULL_SPAN : v;
  endfunction

  function automatic logic [`CTM_CNT_W:0] ctm_p_point(input logic [`CTM_P_W-1:0] p);
    ctm_p_point = ctm_target({1'b0, p, {`CTM_P_SHIFT{1'b0}}});
  endfunction

endpackage

// file: logic/ctm_counter.sv
// 10-bit up-counter with comparators a and p and the clear selection
`timescale 1ns/1ps
`default_nettype none
`include "ctm_defines.svh"

module ctm_counter
  import ctm_pkg::*;
#(
  parameter int CNT_W = `CTM_CNT_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire ctm_ctrl_s ctrl,
  input wire logic restart,
  output logic [CNT_W-1:0] count,
  output logic hit_a,
  output logic hit_p,
  output logic period_clr
);

  initial begin
    if (CNT_W != `CTM_CNT_W) $error("ctm_counter: only a 10-bit counter is supported");
  end

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } ctm_cnt_state_s;

  ctm_cnt_state_s st;
  ctm_cnt_state_s next_st;
  logic run;
  logic [CNT_W:0] inc;
  logic raw_a;
  logic raw_p;

  always_comb begin
    next_st = st;
    run = ctrl.on && !ctrl.pause; // [R20] [R21]
    inc = {1'b0, st.cnt} + {{CNT_W{1'b0}}, 1'b1};
    // the residual count in the restart cycle must not raise a match
    raw_p = run && !restart && (inc == ctm_p_point(ctrl.compare_p_value)); // [R11] [R20]
    raw_a = run && !restart && (inc == ctm_target({1'b0, ctrl.compare_a_value})); // [R19] [R20]
    if (ctrl.mode == CTM_MODE_PWM) begin
      // clear-select is ignored; the period comparator clears
      hit_a = raw_a; // [R12]
      hit_p = raw_p; // [R12]
      period_clr = ctrl.dpx ? raw_a : raw_p; // [R9] [R10] [R17]
    end else if (ctrl.cclr) begin
      // zero compare a value: plain overflow, no a flag
      hit_a = raw_a && (ctrl.compare_a_value != '0); // [R3] [R4]
      hit_p = 1'b0; // [R3]
      period_clr = hit_a || inc[CNT_W]; // [R1] [R3] [R4]
    end else begin
      hit_a = raw_a && (ctrl.compare_a_value != '0); // [R2]
      hit_p = raw_p; // [R2]
      period_clr = raw_p; // [R1] [R2]
    end
    if (restart) begin
      next_st.cnt = '0; // [R18] [R20]
    end else if (run) begin
      next_st.cnt = period_clr ? '0 : inc[CNT_W-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign count = st.cnt;

endmodule // ctm_counter

`default_nettype wire

// file: test/ctm_pin_load.sv
// external load on the timer pin: counts the cycles the line sits high
`timescale 1ns/1ps
`default_nettype none

module ctm_pin_load (
  input wire logic aclk,
  input wire logic clr,
  input wire logic drive,
  input wire logic drive_en,
  output logic pin,
  output logic [15:0] high_cnt
);
  // pull-down on the board holds the line low once the timer lets go
  assign pin = drive_en ? drive : 1'b0;
  always_ff @(posedge aclk) begin
    if (clr) begin
      high_cnt <= '0;
    end else if (pin) begin
      high_cnt <= high_cnt + 16'h1;
    end
  end
endmodule // ctm_pin_load

`default_nettype wire

// file: test/compact_timer_modes_bench.sv
// self-checking bench for the compact timer, driven over axi4-lite
`timescale 1ns/1ps
`default_nettype none
`include "ctm_defines.svh"

module compact_timer_modes_bench;
  import ctm_pkg::*;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, timer_out, timer_out_en, clr, pin;
  logic match_a, match_p;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d, d2;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r2;
  logic [15:0] high_cnt;
  int failures, checked;

  ctm_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .timer_out(timer_out),
    .timer_out_en(timer_out_en), .match_a_flag(match_a), .match_p_flag(match_p));
  ctm_pin_load load (.aclk(aclk), .clr(clr), .drive(timer_out), .drive_en(timer_out_en),
    .pin(pin), .high_cnt(high_cnt));

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  task automatic conclude();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // handshakes are judged on settled values before the edge, released after it
  task automatic wr(input logic [7:0] a, input logic [31:0] dt, output logic [1:0] r);
    logic ta, tw, tb;
    int n;
    tb = 1'b0;
    n = 0;
    awaddr <= a;
    wdata <= dt;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!tb && n < 200) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      r = bresp;
      n++;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    if (!tb) begin
      failures++;
      $display("[ERR] write response expected bvalid seen none");
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] dt, output logic [1:0] r);
    logic ta, tr;
    int n;
    tr = 1'b0;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    while (!tr && n < 200) begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid;
      dt = rdata;
      r = rresp;
      n++;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end
    if (!tr) begin
      failures++;
      $display("[ERR] read response expected rvalid seen none");
    end
  endtask

  task automatic w(input logic [7:0] a, input logic [31:0] dt);
    logic [1:0] r;
    wr(a, dt, r);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] dt;
    logic [1:0] r;
    rd(a, dt, r);
    chk($sformatf("register %h", a), e, dt);
  endtask

  task automatic pin_is(input logic e);
    @(negedge aclk);
    chk("timer_out", {31'h0, e}, {31'h0, timer_out});
    chk("timer_out_en", 32'h1, {31'h0, timer_out_en});
    @(posedge aclk);
  endtask

  // timer is always stopped before mode or output function change
  task automatic cfg(input logic [7:0] c1, input logic [9:0] a, input logic [7:0] c0);
    w(`CTM_OFS_CTRL0, 32'h0);
    w(`CTM_OFS_CTRL1, {24'h0, c1});
    w(`CTM_OFS_CMPA, {22'h0, a});
    w(`CTM_OFS_FLAGS, 32'h3);
    w(`CTM_OFS_CTRL0, {24'h0, c0});
  endtask

  // whole periods only, so the window phase does not matter
  task automatic pwm(input logic [7:0] c1, input logic [9:0] a, input logic [2:0] p, input int win,
    input logic [15:0] e, input logic [1:0] fl);
    cfg(c1, a, {5'h01, p});
    wt(8);
    clr <= 1'b1;
    @(posedge aclk);
    clr <= 1'b0;
    wt(win);
    @(negedge aclk);
    chk("pin high cycles", {16'h0, e}, {16'h0, high_cnt});
    chk("match flag outputs", {30'h0, fl}, {30'h0, match_p, match_a});
    chk("timer_out_en", 32'h1, {31'h0, timer_out_en});
    @(posedge aclk);
    rc(`CTM_OFS_FLAGS, {30'h0, fl});
  endtask

  initial begin
    aresetn = 1'b0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hf;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    bready = 1'b1;
    rready = 1'b1;
    clr = 1'b1;
    failures = 0;
    checked = 0;
    wt(10);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc(`CTM_OFS_CTRL0, 32'h0);
    rc(`CTM_OFS_CTRL1, 32'h0);
    rc(`CTM_OFS_CMPA, 32'h0);
    rc(`CTM_OFS_FLAGS, 32'h0);
    wr(`CTM_OFS_COUNT, 32'h55, r2);
    chk("count write resp", {30'h0, `CTM_RESP_OKAY}, {30'h0, r2});
    rc(`CTM_OFS_COUNT, 32'h0);
    wr(8'h14, 32'h1, r2);
    chk("unmapped write resp", {30'h0, `CTM_RESP_SLVERR}, {30'h0, r2});
    rd(8'h14, d, r2);
    chk("unmapped read resp", {30'h0, `CTM_RESP_SLVERR}, {30'h0, r2});
    chk("unmapped read data", 32'h0, d);
    // compare mode, toggle, clear on p at 384
    cfg(8'h30, 10'h4, 8'h0b);
    rc(`CTM_OFS_CTRL1, 32'h30);
    wt(150);
    pin_is(1'b1);
    wt(300);
    pin_is(1'b0);
    rc(`CTM_OFS_FLAGS, 32'h3);
    w(`CTM_OFS_FLAGS, 32'h3);
    rc(`CTM_OFS_FLAGS, 32'h0);
    // clear on a at 200, p below a, drive low, initial high
    cfg(8'h19, 10'd200, 8'h09);
    wt(50);
    pin_is(1'b1);
    wt(200);
    pin_is(1'b0);
    rc(`CTM_OFS_FLAGS, 32'h1);
    rd(`CTM_OFS_COUNT, d, r2);
    chk("count below a", 32'h1, {31'h0, d < 32'd200});
    cfg(8'h09, 10'h4, 8'h09);
    wt(100);
    pin_is(1'b1);
    cfg(8'h01, 10'h0, 8'h09);
    wt(1100);
    rc(`CTM_OFS_FLAGS, 32'h0);
    // timer mode, pause and stop
    cfg(8'hf0, 10'h4, 8'h08);
    wt(100);
    @(negedge aclk);
    chk("timer_out_en", 32'h0, {31'h0, timer_out_en});
    @(posedge aclk);
    rc(`CTM_OFS_FLAGS, 32'h1);
    w(`CTM_OFS_CTRL0, 32'h88);
    rd(`CTM_OFS_COUNT, d, r2);
    wt(30);
    rc(`CTM_OFS_COUNT, d);
    w(`CTM_OFS_CTRL0, 32'h08);
    wt(30);
    rd(`CTM_OFS_COUNT, d2, r2);
    chk("count resumes", 32'h1, {31'h0, (d2 > d) && (d2 < d + 32'd60)});
    w(`CTM_OFS_CTRL0, 32'h00);
    rd(`CTM_OFS_COUNT, d, r2);
    wt(30);
    rc(`CTM_OFS_COUNT, d);
    w(`CTM_OFS_CTRL0, 32'h08);
    wt(5);
    rd(`CTM_OFS_COUNT, d2, r2);
    chk("count restarts", 32'h1, {31'h0, d2 < 32'd20});
    // pwm: period 128 from p (1024 for p 000 in the last case), duty from a; the swapped case takes period 256 from a
    pwm(8'ha8, 10'd32, 3'h1, 1280, 16'd320, 2'h3);
    pwm(8'ha9, 10'd32, 3'h1, 1280, 16'd320, 2'h3);
    pwm(8'haa, 10'd256, 3'h1, 1280, 16'd640, 2'h3);
    pwm(8'hac, 10'd32, 3'h1, 1280, 16'd960, 2'h3);
    pwm(8'ha0, 10'd32, 3'h1, 1280, 16'd960, 2'h3);
    pwm(8'ha8, 10'd200, 3'h1, 1280, 16'd1280, 2'h2);
    pwm(8'h88, 10'd32, 3'h1, 1280, 16'd0, 2'h3);
    pwm(8'h98, 10'd32, 3'h1, 1280, 16'd1280, 2'h3);
    pwm(8'ha8, 10'h201, 3'h0, 2048, 16'd1026, 2'h3);
    conclude();
  end

  // tests take about 15000 cycles
  initial begin
    wt(60000);
    failures++;
    conclude();
  end
endmodule // compact_timer_modes_bench

`default_nettype wire
